/* File: verilog/bpg_pkg.sv */
// package: register map, reset values and carrier types of the beep tone generator
// Function
// - enable bit starts beep, self-clears after duration
// - auto bit starts beep on pen touch
// - left volume 6-bit, +2 dB down 1 dB/step
// - right volume same scale, separate code
// - link field copies one channel volume to other
// - tone only in beep-capable DAC processing mode
// - tone lasts exactly 24-bit sample count
// - duration resets to 0xEE samples
// - sine coefficient high byte resets 0x10
// - sine coefficient low byte resets 0xD8
// - cosine coefficient resets 0x7EE3 in two bytes
package bpg_pkg;
    // register offsets
    localparam logic [6:0] BPG_LEFT_CTL = 7'h47;
    localparam logic [6:0] BPG_RIGHT_CTL = 7'h48;
    localparam logic [6:0] BPG_LEN_HIGH = 7'h49;
    localparam logic [6:0] BPG_LEN_MID = 7'h4A;
    localparam logic [6:0] BPG_LEN_LOW = 7'h4B;
    localparam logic [6:0] BPG_SIN_HIGH = 7'h4C;
    localparam logic [6:0] BPG_SIN_LOW = 7'h4D;
    localparam logic [6:0] BPG_COS_HIGH = 7'h4E;
    localparam logic [6:0] BPG_COS_LOW = 7'h4F;
    // field positions
    localparam int BPG_ENABLE_BIT = 7;
    localparam int BPG_AUTO_BIT = 6;
    // values after reset
    localparam logic [7:0] BPG_CTL_RST = 8'h00;
    localparam logic [7:0] BPG_LEN_HIGH_RST = 8'h00;
    localparam logic [7:0] BPG_LEN_MID_RST = 8'h00;
    localparam logic [7:0] BPG_LEN_LOW_RST = 8'hEE;
    localparam logic [7:0] BPG_SIN_HIGH_RST = 8'h10;
    localparam logic [7:0] BPG_SIN_LOW_RST = 8'hD8;
    localparam logic [7:0] BPG_COS_HIGH_RST = 8'h7E;
    localparam logic [7:0] BPG_COS_LOW_RST = 8'hE3;
    // link field codes
    localparam logic [1:0] BPG_LINK_R2L = 2'h1;
    localparam logic [1:0] BPG_LINK_L2R = 2'h2;
    // volume: 6 codes per factor of two, fine gains in Q14
    localparam logic [5:0] BPG_STEPS_PER_OCT = 6'h06;
    localparam int BPG_FINE_FRAC = 14;
    // register port request
    typedef struct packed {
        logic wr; // write strobe, one cycle
        logic rd; // read strobe, one cycle
        logic [6:0] addr; // register offset
        logic [7:0] wdata; // write byte
    } bpg_req_s;
    // stereo sample pair
    typedef struct packed {
        logic signed [15:0] left;
        logic signed [15:0] right;
    } bpg_smp_s;
endpackage

/* File: verilog/bpg_beep_gen.sv */
// module: beep tone generator with byte register port
module bpg_beep_gen
    import bpg_pkg::*;
(
    input wire logic mclk, // system clock, 50 MHz
    input wire logic rst, // synchronous reset, active high
    input wire bpg_req_s reg_req, // register access request
    output logic [7:0] reg_rdata_r, // read data, one cycle after rd
    input wire logic wclk_en, // dac word clock tick, one cycle pulse
    input wire logic beep_capable_dac_processing_mode, // mode level
    input wire logic codec_input_clock_ok, // codec clock running
    input wire logic pen_touch, // touch detected level
    output bpg_smp_s beep_out_r, // scaled tone samples
    output logic beep_active_r // tone generation in progress
);
    // control state
    typedef enum logic {ST_IDLE, ST_RUN} bpg_state_e;
    bpg_state_e state_r, state_nxt;
    // register bytes
    logic auto_r; // auto beep on touch
    logic [5:0] vol_l_r, vol_r_r; // programmed volume codes
    logic [1:0] link_r; // volume link field
    logic [23:0] len_r; // duration in samples
    logic [15:0] sin_r, cos_r; // oscillator coefficients
    logic [23:0] cnt_r, cnt_nxt; // samples left to produce
    logic signed [15:0] y1_r, y2_r; // oscillator history
    logic pen_d_r; // delayed touch for edge detect
    // decode of writes
    wire wr_left = reg_req.wr && reg_req.addr == BPG_LEFT_CTL;
    wire wr_right = reg_req.wr && reg_req.addr == BPG_RIGHT_CTL;
    wire sw_start = wr_left && reg_req.wdata[BPG_ENABLE_BIT];
    wire sw_stop = wr_left && !reg_req.wdata[BPG_ENABLE_BIT];
    wire touch_start = auto_r && pen_touch && !pen_d_r
        && codec_input_clock_ok;
    wire start = sw_start || touch_start;
    // a tick counts a sample only in the beep-capable mode
    wire tick_ok = wclk_en && beep_capable_dac_processing_mode;
    wire last = state_r == ST_RUN && tick_ok && cnt_r == 24'h000001;
    // effective volume codes after link selection
    wire [5:0] vol_l_eff = (link_r == BPG_LINK_R2L) ? vol_r_r : vol_l_r;
    wire [5:0] vol_r_eff = (link_r == BPG_LINK_L2R) ? vol_l_r : vol_r_r;
    // oscillator step: y = 2*cos*y1 - y2
    wire signed [31:0] osc_prod = $signed(cos_r) * y1_r;
    wire signed [31:0] osc_shift = osc_prod >>> (BPG_FINE_FRAC);
    wire signed [15:0] y_new = osc_shift[15:0] - y2_r;
    // start point: y1 at half-scale sine so peaks stay in range
    wire signed [15:0] sin_half = $signed(sin_r) >>> 1;
    // read multiplexer
    wire [7:0] rd_mux =
        (reg_req.addr == BPG_LEFT_CTL) ?
            {state_r == ST_RUN, auto_r, vol_l_r} :
        (reg_req.addr == BPG_RIGHT_CTL) ? {link_r, vol_r_r} :
        (reg_req.addr == BPG_LEN_HIGH) ? len_r[23:16] :
        (reg_req.addr == BPG_LEN_MID) ? len_r[15:8] :
        (reg_req.addr == BPG_LEN_LOW) ? len_r[7:0] :
        (reg_req.addr == BPG_SIN_HIGH) ? sin_r[15:8] :
        (reg_req.addr == BPG_SIN_LOW) ? sin_r[7:0] :
        (reg_req.addr == BPG_COS_HIGH) ? cos_r[15:8] :
        (reg_req.addr == BPG_COS_LOW) ? cos_r[7:0] : 8'h00;

    // per channel volume: shift by whole octaves, fine gain by table
    wire [5:0] vol_eff [2];
    wire signed [15:0] scaled [2];
    assign vol_eff[0] = vol_l_eff;
    assign vol_eff[1] = vol_r_eff;
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_vol
            wire [5:0] oct = vol_eff[ch] / BPG_STEPS_PER_OCT;
            wire [5:0] rem = vol_eff[ch] % BPG_STEPS_PER_OCT;
            // Q14 gain for codes +2,+1,0,-1,-2,-3 dB within an octave
            wire signed [15:0] fine =
                (rem == 6'h00) ? 16'sh5092 :
                (rem == 6'h01) ? 16'sh47CF :
                (rem == 6'h02) ? 16'sh4000 :
                (rem == 6'h03) ? 16'sh390A :
                (rem == 6'h04) ? 16'sh32D6 : 16'sh2D4F;
            wire signed [31:0] prod = y_new * fine;
            wire signed [31:0] sh = (prod >>> BPG_FINE_FRAC) >>> oct;
            assign scaled[ch] = sh[15:0];
        end
    endgenerate

    // next state and sample count
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            ST_IDLE: begin
                // a zero duration produces no samples
                if (start && len_r != 24'h000000) begin
                    state_nxt = ST_RUN;
                    cnt_nxt = len_r;
                end
            end
            ST_RUN: begin
                if (start) begin
                    // a new start restarts and wins over the self clear
                    cnt_nxt = len_r;
                    if (len_r == 24'h000000) begin
                        state_nxt = ST_IDLE;
                    end
                end else if (sw_stop) begin
                    state_nxt = ST_IDLE;
                end else if (last) begin
                    state_nxt = ST_IDLE;
                end else if (tick_ok) begin
                    cnt_nxt = cnt_r - 24'h000001;
                end
            end
        endcase
    end

    // control state registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cnt_r <= 24'h000000;
            pen_d_r <= 1'b0;
            beep_active_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pen_d_r <= pen_touch;
            beep_active_r <= state_nxt == ST_RUN;
        end
    end

    // control byte registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            auto_r <= BPG_CTL_RST[BPG_AUTO_BIT];
            vol_l_r <= BPG_CTL_RST[5:0];
            link_r <= BPG_CTL_RST[7:6];
            vol_r_r <= BPG_CTL_RST[5:0];
        end else if (wr_left) begin
            auto_r <= reg_req.wdata[BPG_AUTO_BIT];
            vol_l_r <= reg_req.wdata[5:0];
        end else if (wr_right) begin
            link_r <= reg_req.wdata[7:6];
            vol_r_r <= reg_req.wdata[5:0];
        end
    end

    // duration and coefficient bytes
    always_ff @(posedge mclk) begin
        if (rst) begin
            len_r <= {BPG_LEN_HIGH_RST, BPG_LEN_MID_RST, BPG_LEN_LOW_RST};
            sin_r <= {BPG_SIN_HIGH_RST, BPG_SIN_LOW_RST};
            cos_r <= {BPG_COS_HIGH_RST, BPG_COS_LOW_RST};
        end else if (reg_req.wr) begin
            unique case (reg_req.addr)
                BPG_LEN_HIGH: len_r[23:16] <= reg_req.wdata;
                BPG_LEN_MID: len_r[15:8] <= reg_req.wdata;
                BPG_LEN_LOW: len_r[7:0] <= reg_req.wdata;
                BPG_SIN_HIGH: sin_r[15:8] <= reg_req.wdata;
                BPG_SIN_LOW: sin_r[7:0] <= reg_req.wdata;
                BPG_COS_HIGH: cos_r[15:8] <= reg_req.wdata;
                BPG_COS_LOW: cos_r[7:0] <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // read data register, unmapped offsets read zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_req.rd) begin
            reg_rdata_r <= rd_mux;
        end
    end

    // oscillator history and output samples
    always_ff @(posedge mclk) begin
        if (rst) begin
            y1_r <= 16'sh0000;
            y2_r <= 16'sh0000;
            beep_out_r <= '0;
        end else if (state_r == ST_IDLE || start) begin
            // prime so the first sample is y = 2c*s/2 - 0, from y1 = s/2 and y2 = 0
            y1_r <= sin_half;
            y2_r <= 16'sh0000;
            beep_out_r <= '0;
        end else if (tick_ok) begin
            y1_r <= y_new;
            y2_r <= y1_r;
            beep_out_r.left <= scaled[0];
            beep_out_r.right <= scaled[1];
        end
    end

    // checks
    property p_self_clear;
        @(posedge mclk) disable iff (rst)
        last && !start && !sw_stop |=> state_r == ST_IDLE && !beep_active_r;
    endproperty
    a_self_clear: assert property (p_self_clear)
        else $error("enable did not clear at end of duration");

    property p_sw_start;
        @(posedge mclk) disable iff (rst)
        sw_start && len_r != 24'h000000 |=> state_r == ST_RUN && cnt_r ==
            $past(len_r);
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("write of enable did not start the beep");

    property p_touch_start;
        @(posedge mclk) disable iff (rst)
        touch_start && len_r != 24'h000000 |=> beep_active_r;
    endproperty
    a_touch_start: assert property (p_touch_start)
        else $error("pen touch did not start the beep");

    property p_mode_gate;
        @(posedge mclk) disable iff (rst)
        !beep_capable_dac_processing_mode && !start && state_r == ST_RUN
            |=> $stable(beep_out_r) && $stable(cnt_r);
    endproperty
    a_mode_gate: assert property (p_mode_gate)
        else $error("tone advanced outside the beep mode");

    property p_count;
        @(posedge mclk) disable iff (rst)
        state_r == ST_RUN && tick_ok && !start && !sw_stop && !last
            |=> cnt_r == $past(cnt_r) - 24'h000001;
    endproperty
    a_count: assert property (p_count)
        else $error("sample count did not step down by one");

    property p_reset_len;
        @(posedge mclk) $past(rst) && !rst |-> len_r == 24'h0000EE;
    endproperty
    a_reset_len: assert property (p_reset_len)
        else $error("duration not 0xEE after reset");

    property p_reset_coef;
        @(posedge mclk) $past(rst) && !rst |-> sin_r == 16'h10D8 &&
            cos_r == 16'h7EE3;
    endproperty
    a_reset_coef: assert property (p_reset_coef)
        else $error("coefficients wrong after reset");

    property p_link;
        @(posedge mclk) disable iff (rst)
        (link_r == 2'h1 |-> vol_l_eff == vol_r_r && vol_r_eff == vol_r_r) and
        (link_r == 2'h2 |-> vol_r_eff == vol_l_r && vol_l_eff == vol_l_r);
    endproperty
    a_link: assert property (p_link)
        else $error("volume link selects the wrong source");

    property p_unity_left;
        @(posedge mclk) disable iff (rst)
        vol_l_eff == 6'h02 |-> g_vol[0].fine == 16'sh4000 &&
            g_vol[0].oct == 6'h00;
    endproperty
    a_unity_left: assert property (p_unity_left)
        else $error("left code 2 is not unity gain");

    property p_floor_right;
        @(posedge mclk) disable iff (rst)
        vol_r_eff == 6'h3F |-> g_vol[1].oct == 6'h0A &&
            g_vol[1].fine == 16'sh390A;
    endproperty
    a_floor_right: assert property (p_floor_right)
        else $error("right all-ones code is not the -61 dB gain");
endmodule // bpg_beep_gen

/* File: testbench/bpg_dac_model.sv */
// dac word clock source: one-cycle tick every DIV system clocks
module bpg_dac_model
    import bpg_pkg::*;
#(
    parameter int DIV = 8 // system clocks per dac sample
)
(
    input wire logic mclk, // system clock
    input wire logic rst, // synchronous reset, active high
    output logic wclk_en // word clock tick, one cycle pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] div_r; // divider count
    logic wrap; // divider at its last state
    assign wrap = (div_r == 8'(DIV - 1));
    // free-running divider, tick launched on the wrap
    always_ff @(posedge mclk) begin
        if (rst) begin
            div_r <= 8'h00;
            wclk_en <= 1'b0;
        end else begin
            div_r <= wrap ? 8'h00 : div_r + 8'h01;
            wclk_en <= wrap;
        end
    end
endmodule // bpg_dac_model

/* File: testbench/tb_top.sv */
// testbench: register sequences and beep timing checks
module tb_top
    import bpg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0; // 50 MHz clock
    logic rst = 1'b1; // synchronous reset
    logic mode = 1'b1; // beep-capable processing mode
    logic clk_ok = 1'b1; // codec input clock running
    logic pen_touch = 1'b0; // touch detector level
    bpg_req_s reg_req = '0; // register request
    logic [7:0] reg_rdata_r; // read data
    bpg_smp_s beep_out_r; // tone samples
    logic beep_active_r; // beep running
    logic wclk_en; // word clock tick from the model
    int err_count = 0; // mismatches
    int n_checks = 0; // comparisons
    // register map and values after reset
    logic [6:0] ra [9] = '{BPG_LEFT_CTL, BPG_RIGHT_CTL, BPG_LEN_HIGH,
        BPG_LEN_MID, BPG_LEN_LOW, BPG_SIN_HIGH, BPG_SIN_LOW, BPG_COS_HIGH,
        BPG_COS_LOW};
    logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hEE, 8'h10,
        8'hD8, 8'h7E, 8'hE3};
    // clock
    always #10 mclk = ~mclk;
    bpg_beep_gen i_bpg_beep_gen(.mclk(mclk), .rst(rst), .reg_req(reg_req),
        .reg_rdata_r(reg_rdata_r), .wclk_en(wclk_en),
        .beep_capable_dac_processing_mode(mode),
        .codec_input_clock_ok(clk_ok), .pen_touch(pen_touch),
        .beep_out_r(beep_out_r), .beep_active_r(beep_active_r));
    bpg_dac_model i_bpg_dac_model(.mclk(mclk), .rst(rst),
        .wclk_en(wclk_en));
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // counts and verdict, ends the run
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one register write, strobe held for one edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        reg_req.wr <= 1'b0;
    endtask
    // one register read, data taken after the answering edge
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        reg_req.rd <= 1'b0;
        #1;
        d = reg_rdata_r;
    endtask
    // counts counted ticks until the beep ends, bounded
    task automatic run_len(output int n);
        n = 0;
        for (int i = 0; i < 4000; i++) begin
            @(negedge mclk);
            if (beep_active_r !== 1'b1) begin
                return;
            end
            if (wclk_en && mode) begin
                n++;
            end
        end
        err_count++;
        test_done();
    endtask
    // waits k counted ticks, then lets the outputs settle
    task automatic ticks(input int k);
        int c;
        c = 0;
        for (int i = 0; i < 1000 && c < k; i++) begin
            @(negedge mclk);
            if (wclk_en && mode) begin
                c++;
            end
        end
        // too few ticks within the bound counts as a mismatch
        if (c < k) begin
            err_count++;
            test_done();
        end
        repeat (2) @(negedge mclk);
    endtask
    // main sequence
    initial begin
        logic [7:0] d;
        int n;
        int diff;
        logic eq;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rd(ra[i], d);
            chk(d, rv[i]);
        end
        wr(BPG_SIN_LOW, 8'h5A);
        rd(BPG_SIN_LOW, d);
        chk(d, 8'h5A);
        wr(7'h50, 8'hFF);
        rd(7'h50, d);
        chk(d, 8'h00);
        wr(BPG_SIN_LOW, BPG_SIN_LOW_RST);
        $display("test registers done");
        // default length, then 258 and 1 samples
        wr(BPG_LEFT_CTL, 8'h82);
        run_len(n);
        chk(n, 32'hEE);
        rd(BPG_LEFT_CTL, d);
        chk(d, 8'h02);
        wr(BPG_LEN_MID, 8'h01);
        wr(BPG_LEN_LOW, 8'h02);
        wr(BPG_LEFT_CTL, 8'h82);
        run_len(n);
        chk(n, 32'h102);
        wr(BPG_LEN_MID, 8'h00);
        wr(BPG_LEN_LOW, 8'h01);
        wr(BPG_LEFT_CTL, 8'h82);
        run_len(n);
        chk(n, 32'h1);
        $display("test duration done");
        // ticks outside the beep mode are not counted
        wr(BPG_LEN_LOW, 8'h02);
        @(posedge mclk);
        mode <= 1'b0;
        wr(BPG_LEFT_CTL, 8'h82);
        repeat (40) @(negedge mclk);
        chk(beep_active_r, 1'b1);
        chk(beep_out_r, 32'h0);
        @(posedge mclk);
        mode <= 1'b1;
        run_len(n);
        chk(n, 32'h2);
        $display("test mode done");
        // pen touch start, needs the codec clock
        wr(BPG_LEN_LOW, 8'h40);
        wr(BPG_LEFT_CTL, 8'h42);
        @(posedge mclk);
        clk_ok <= 1'b0;
        pen_touch <= 1'b1;
        repeat (3) @(negedge mclk);
        chk(beep_active_r, 1'b0);
        @(posedge mclk);
        pen_touch <= 1'b0;
        clk_ok <= 1'b1;
        @(posedge mclk);
        pen_touch <= 1'b1;
        repeat (3) @(negedge mclk);
        chk(beep_active_r, 1'b1);
        wr(BPG_LEFT_CTL, 8'h02);
        @(negedge mclk);
        chk(beep_active_r, 1'b0);
        // the last sample stands one more cycle before the output clears
        @(negedge mclk);
        chk(beep_out_r, 32'h0);
        @(posedge mclk);
        pen_touch <= 1'b0;
        $display("test touch done");
        // left code 2, right code 8, every link code
        for (int lk = 0; lk < 4; lk++) begin
            wr(BPG_RIGHT_CTL, {2'(lk), 6'h08});
            wr(BPG_LEFT_CTL, 8'h82);
            ticks(4);
            eq = (lk == 1 || lk == 2);
            chk(beep_out_r.left == beep_out_r.right, eq);
            chk(beep_out_r.left != 16'h0000, 1'b1);
            if (!eq) begin
                diff = int'(beep_out_r.left) - 2 * int'(beep_out_r.right);
                chk(diff inside {[-4:4]}, 1'b1);
            end
            wr(BPG_LEFT_CTL, 8'h02);
        end
        // right all-ones code sits near -61 dB below the unity left
        wr(BPG_RIGHT_CTL, 8'h3F);
        wr(BPG_LEFT_CTL, 8'h82);
        ticks(4);
        chk(beep_out_r.left != 16'h0000, 1'b1);
        diff = int'(beep_out_r.left) / 1122 - int'(beep_out_r.right);
        chk(diff inside {[-2:2]}, 1'b1);
        wr(BPG_LEFT_CTL, 8'h02);
        $display("test volume done");
        test_done();
    end
endmodule // tb_top
